// ===== hdl/dsf_pkg.sv
// Constants, register map and carrier types of the drive status flag block.
// Assumes one 250 MHz system clock; all times derive from its period.
package dsf_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_NS = 10_000_000;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned MIN_ON_NS = 100_000_000;
  localparam logic [3:0] MIN_ON_TICKS = 4'(MIN_ON_NS / TICK_NS);
  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_ARR_HYS = 8'h00;
  localparam logic [7:0] OFS_DET_LVL = 8'h04;
  localparam logic [7:0] OFS_DET_HYS = 8'h08;
  localparam logic [7:0] OFS_CUR_LVL_A = 8'h0c;
  localparam logic [7:0] OFS_CUR_TMR_A = 8'h10;
  localparam logic [7:0] OFS_CUR_LVL_B = 8'h14;
  localparam logic [7:0] OFS_CUR_TMR_B = 8'h18;
  localparam logic [7:0] OFS_MODES = 8'h1c;
  localparam logic [7:0] OFS_THERM_TRIP = 8'h20;
  localparam logic [7:0] OFS_TERM_SEL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam int RESTART_LSB = 0;
  localparam int THERM_LSB = 4;
  localparam int SEL_Y_LSB = 0;
  localparam int SEL_R_LSB = 16;
  localparam logic [15:0] RST_ARR_HYS = 16'h00fa;
  localparam logic [15:0] RST_DET_LVL = 16'h1770;
  localparam logic [15:0] RST_DET_HYS = 16'h0064;
  localparam logic [7:0] RST_CUR_LVL = 8'h64;
  localparam logic [15:0] RST_CUR_TMR = 16'h03e8;
  localparam logic [2:0] RST_RESTART = 3'h0;
  localparam logic [1:0] RST_THERM = 2'h0;
  localparam logic [15:0] RST_THERM_TRIP = 16'h0fa0;
  localparam logic [10:0] RST_SEL_Y = 11'h000;
  localparam logic [10:0] RST_SEL_R = 11'h063;
  // ****************************************
  // Ranges and codes
  // ****************************************
  localparam logic [7:0] LVL_MAX = 8'hc8;
  localparam logic [15:0] TMR_MIN = 16'h0001;
  localparam logic [15:0] TMR_MAX = 16'hea60;
  localparam logic [15:0] PCT_SCALE = 16'h0064;
  localparam logic [15:0] FIVE_PCT = 16'h01f4;
  localparam logic [10:0] INV_OFFSET = 11'h3e8;
  localparam logic [2:0] RESTART_DIP_A = 3'h4;
  localparam logic [2:0] RESTART_DIP_B = 3'h5;
  localparam logic [1:0] THERM_PTC = 2'h2;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] outFreq;
    logic [15:0] refFreq;
    logic [15:0] startFreq;
    logic [15:0] stopFreq;
    logic [15:0] dcVolt;
    logic [15:0] uvLevel;
    logic [15:0] outCurrent;
    logic [15:0] motorTemp;
  } dsf_meas_t;
  typedef struct packed {
    logic uvTrip;
    logic swCurLimit;
    logic hwCurLimit;
    logic regenDecel;
    logic ovlPrevActive;
    logic rideThrough;
    logic dcCapExpired;
    logic pcbCapExpired;
    logic fanExpired;
    logic dcBraking;
    logic slowFlowStop;
    logic brakeReq;
    logic c1IsFeedback;
    logic c1WireBroken;
    logic alarmActive;
  } dsf_evt_t;
  typedef struct packed {
    logic alarmAny;
    logic arrivalAndDetect;
    logic feedbackWireBreak;
    logic brakeCommand;
    logic thermistorOverheat;
    logic secondMotorSelected;
    logic slowFlowStopped;
    logic closedLoopActive;
    logic lowCurrentFlag;
    logic currentDetectedB;
    logic currentDetectedA;
    logic overloadPreventionFlag;
    logic outputActiveInclBraking;
    logic wearoutAlarm;
    logic overloadWarning;
    logic powerDipRestart;
    logic outputLimitingFlag;
    logic undervoltageFlag;
    logic freqDetectFlag;
    logic freqArrival;
    logic outputActiveFlag;
  } dsf_flags_t;
endpackage : dsf_pkg

// ===== hdl/dsf_status_flags.sv
// Status flag generator of a motor drive, with two programmable terminals.
// Assumes measurements and events come from logic on sys_clk; the three
// terminal commands come from pins and are synchronised here.
`timescale 1ns/100ps
// Operation
// R01: Arrival flag when output is within hysteresis of reference frequency.
// R02: Detect flag sets above level, clears only below level minus hysteresis.
// R03: Undervoltage flag below level, released above it, held during trip.
// R04: While undervoltage flag is on, run commands are ignored.
// R05: Limiting flag on current limit or regen decel; 100 ms minimum.
// R06: Power dip flag only for restart mode 4 or 5, until arrival.
// R07: Overload warning when current exceeds current level A.
// R08: Wearout flag when any capacitor or fan life has expired.
// R09: Running-2 flag equals running flag but stays on during DC braking.
// R10: Overload prevention flag while active; 100 ms minimum.
// R11: Current detect A/B when current above level longer than timer; 100 ms.
// R12: Current detect A/B released below 90% of own level.
// R13: Low current after below level A for timer A; off above B plus 5%.
// R14: Closed loop flag when loop cancel is off and run is on.
// R15: Slow flow flag while stopped by slow-flowrate stop.
// R16: Second motor flag while motor select command picks motor 2.
// R17: Thermistor flag in mode 2 when temperature reaches trip level.
// R18: Brake flag carries the mechanical brake command.
// R19: Wire break flag when feedback input is the current terminal and broken.
// R20: Arrival-and-detect flag is the AND of arrival and detect flags.
// R21: Alarm flag whenever a protective function puts the drive in alarm.
// R22: Levels 0 or 1 to 200 percent; timers 0.01 to 600 s accepted.
// R23: Terminal code selects a flag; code plus 1000 inverts it.
// R24: Running flag above start, cleared below stop and during DC braking.
// R25: Each minimum ON width is a hold counter started by assertion.
module dsf_status_flags import dsf_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int HOLD_N = 5
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  // Drive state
  input wire dsf_meas_t meas,
  input wire dsf_evt_t evt,
  // Terminal command pins
  input wire logic runCmdPin,
  input wire logic loopCancelPin,
  input wire logic motorSelectPin,
  // Results
  output logic motorStartEn,
  output dsf_flags_t flags,
  output logic termY,
  output logic termRelay
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] absDiff(logic [15:0] a, logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absDiff

  function automatic logic [15:0] pctToCur(logic [7:0] p);
    return 16'({8'h00, p} * PCT_SCALE);
  endfunction : pctToCur

  // Saturating tick counter while a condition holds, cleared otherwise
  function automatic logic [15:0] tmrStep(logic [15:0] c, logic cond,
                                          logic tick);
    if (!cond) return 16'h0000;
    if (tick && c != 16'hffff) return c + 16'h0001;
    return c;
  endfunction : tmrStep

  function automatic logic pickFlag(dsf_flags_t f, logic [10:0] code);
    case (code)
      11'd0: return f.outputActiveFlag;
      11'd1: return f.freqArrival;
      11'd2: return f.freqDetectFlag;
      11'd3: return f.undervoltageFlag;
      11'd5: return f.outputLimitingFlag;
      11'd6: return f.powerDipRestart;
      11'd7: return f.overloadWarning;
      11'd30: return f.wearoutAlarm;
      11'd35: return f.outputActiveInclBraking;
      11'd36: return f.overloadPreventionFlag;
      11'd37: return f.currentDetectedA;
      11'd38: return f.currentDetectedB;
      11'd41: return f.lowCurrentFlag;
      11'd43: return f.closedLoopActive;
      11'd44: return f.slowFlowStopped;
      11'd49: return f.secondMotorSelected;
      11'd56: return f.thermistorOverheat;
      11'd57: return f.brakeCommand;
      11'd59: return f.feedbackWireBreak;
      11'd87: return f.arrivalAndDetect;
      11'd99: return f.alarmAny;
      default: return 1'b0;
    endcase
  endfunction : pickFlag

  function automatic logic termOut(dsf_flags_t f, logic [10:0] sel);
    if (sel >= INV_OFFSET) return ~pickFlag(f, sel - INV_OFFSET); // R23
    return pickFlag(f, sel); // R23
  endfunction : termOut

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] arrHys_reg, detLvl_reg, detHys_reg, thermTrip_reg;
  logic [7:0] lvlA_reg, lvlB_reg;
  logic [15:0] tmrA_reg, tmrB_reg;
  logic [2:0] restartMode_reg;
  logic [1:0] thermMode_reg;
  logic [10:0] selY_reg, selR_reg;
  logic [31:0] rdData_reg;

  wire wrEn = ce && regWrStb;
  wire [7:0] wrLvl = regWrData[7:0];
  wire [15:0] wrTmr = regWrData[15:0];
  wire lvlOk = wrLvl <= LVL_MAX; // R22
  wire tmrOk = wrTmr >= TMR_MIN && wrTmr <= TMR_MAX; // R22
  wire [10:0] wrSelY = regWrData[SEL_Y_LSB +: 11];
  wire [10:0] wrSelR = regWrData[SEL_R_LSB +: 11];
  wire selOk = wrSelY < 11'd1100 && wrSelR < 11'd1100;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arrHys_reg <= RST_ARR_HYS;
      detLvl_reg <= RST_DET_LVL;
      detHys_reg <= RST_DET_HYS;
      lvlA_reg <= RST_CUR_LVL;
      lvlB_reg <= RST_CUR_LVL;
      tmrA_reg <= RST_CUR_TMR;
      tmrB_reg <= RST_CUR_TMR;
      restartMode_reg <= RST_RESTART;
      thermMode_reg <= RST_THERM;
      thermTrip_reg <= RST_THERM_TRIP;
      selY_reg <= RST_SEL_Y;
      selR_reg <= RST_SEL_R;
    end else if (wrEn) begin
      case (regAddr)
        OFS_ARR_HYS: arrHys_reg <= wrTmr;
        OFS_DET_LVL: detLvl_reg <= wrTmr;
        OFS_DET_HYS: detHys_reg <= wrTmr;
        OFS_CUR_LVL_A: if (lvlOk) lvlA_reg <= wrLvl; // R22
        OFS_CUR_TMR_A: if (tmrOk) tmrA_reg <= wrTmr; // R22
        OFS_CUR_LVL_B: if (lvlOk) lvlB_reg <= wrLvl; // R22
        OFS_CUR_TMR_B: if (tmrOk) tmrB_reg <= wrTmr; // R22
        OFS_MODES: begin
          restartMode_reg <= regWrData[RESTART_LSB +: 3];
          thermMode_reg <= regWrData[THERM_LSB +: 2];
        end
        OFS_THERM_TRIP: thermTrip_reg <= wrTmr;
        OFS_TERM_SEL: if (selOk) begin
          selY_reg <= wrSelY;
          selR_reg <= wrSelR;
        end
        default: ;
      endcase
    end
  end

  // Unmapped offsets read as zero
  logic [31:0] rdMux;
  always_comb begin
    case (regAddr)
      OFS_ARR_HYS: rdMux = {16'h0000, arrHys_reg};
      OFS_DET_LVL: rdMux = {16'h0000, detLvl_reg};
      OFS_DET_HYS: rdMux = {16'h0000, detHys_reg};
      OFS_CUR_LVL_A: rdMux = {24'h000000, lvlA_reg};
      OFS_CUR_TMR_A: rdMux = {16'h0000, tmrA_reg};
      OFS_CUR_LVL_B: rdMux = {24'h000000, lvlB_reg};
      OFS_CUR_TMR_B: rdMux = {16'h0000, tmrB_reg};
      OFS_MODES: rdMux = {26'h0, thermMode_reg, 1'b0, restartMode_reg};
      OFS_THERM_TRIP: rdMux = {16'h0000, thermTrip_reg};
      OFS_TERM_SEL: rdMux = {5'h00, selR_reg, 5'h00, selY_reg};
      OFS_STATUS: rdMux = {11'h000, flags};
      default: rdMux = 32'h00000000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rdData_reg <= 32'h00000000;
    else if (ce) rdData_reg <= regRdStb ? rdMux : 32'h00000000;
  end
  assign regRdData = rdData_reg;

  // ****************************************
  // Pin synchronisers and timebase
  // ****************************************
  logic [2:0] pinS1_reg, pinS2_reg, pinS3_reg, pinLvl_reg;
  logic [31:0] tickCnt_reg;
  wire [2:0] pinRaw = {motorSelectPin, loopCancelPin, runCmdPin};
  // A pin level is taken only once the second and third stages agree
  wire [2:0] pinAgree = ~(pinS2_reg ^ pinS3_reg);
  wire tick = tickCnt_reg == 32'(TICK_CYCLES - 1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pinS1_reg <= 3'h0;
      pinS2_reg <= 3'h0;
      pinS3_reg <= 3'h0;
      pinLvl_reg <= 3'h0;
      tickCnt_reg <= 32'h00000000;
    end else if (ce) begin
      pinS1_reg <= pinRaw;
      pinS2_reg <= pinS1_reg;
      pinS3_reg <= pinS2_reg;
      pinLvl_reg <= (pinS2_reg & pinAgree) | (pinLvl_reg & ~pinAgree);
      tickCnt_reg <= tick ? 32'h00000000 : tickCnt_reg + 32'h00000001;
    end
  end
  wire runLvl = pinLvl_reg[0];
  wire loopCancelLvl = pinLvl_reg[1];
  wire motor2Lvl = pinLvl_reg[2];

  // ****************************************
  // Frequency and voltage conditions
  // ****************************************
  logic det_reg, uv_reg, run_reg, dip_reg;
  wire arrivalNow = absDiff(meas.outFreq, meas.refFreq) <= arrHys_reg; // R01
  wire [15:0] detLow = (detLvl_reg > detHys_reg) ?
                       detLvl_reg - detHys_reg : 16'h0000;
  wire detNext = (meas.outFreq > detLvl_reg) ? 1'b1 : // R02
                 (meas.outFreq < detLow) ? 1'b0 : det_reg; // R02
  wire uvNext = (meas.dcVolt < meas.uvLevel) ? 1'b1 : // R03
                (meas.dcVolt > meas.uvLevel) ? 1'b0 : uv_reg; // R03
  wire uvFlag = uv_reg | evt.uvTrip; // R03
  wire runNext = evt.dcBraking ? 1'b0 : // R24
                 (meas.outFreq > meas.startFreq) ? 1'b1 : // R24
                 (meas.outFreq < meas.stopFreq) ? 1'b0 : run_reg; // R24
  wire dipModeOk = restartMode_reg == RESTART_DIP_A ||
                   restartMode_reg == RESTART_DIP_B; // R06
  // Latched from the shutdown until the output arrives again
  wire dipNext = !dipModeOk ? 1'b0 :
                 uvFlag ? 1'b1 : // R06
                 arrivalNow ? 1'b0 : dip_reg; // R06

  // ****************************************
  // Current detection
  // ****************************************
  logic [15:0] cntA_reg, cntB_reg, cntL_reg;
  logic detA_reg, detB_reg, lowCur_reg;
  wire [15:0] curA = pctToCur(lvlA_reg);
  wire [15:0] curB = pctToCur(lvlB_reg);
  wire [19:0] cur10 = 20'({4'h0, meas.outCurrent} * 20'd10);
  wire aboveA = lvlA_reg != 8'h00 && meas.outCurrent > curA; // R11
  wire aboveB = lvlB_reg != 8'h00 && meas.outCurrent > curB; // R11
  wire below90A = cur10 < 20'({4'h0, curA} * 20'd9); // R12
  wire below90B = cur10 < 20'({4'h0, curB} * 20'd9); // R12
  wire belowA = lvlA_reg != 8'h00 && meas.outCurrent < curA; // R13
  wire [16:0] lowCurOff = {1'b0, curB} + {1'b0, FIVE_PCT};
  wire lowCurRelease = {1'b0, meas.outCurrent} >= lowCurOff; // R13
  wire [15:0] cntANext = tmrStep(cntA_reg, aboveA, tick);
  wire [15:0] cntBNext = tmrStep(cntB_reg, aboveB, tick);
  wire [15:0] cntLNext = tmrStep(cntL_reg, belowA, tick);
  wire detANext = (cntA_reg > tmrA_reg) ? 1'b1 : // R11
                  below90A ? 1'b0 : detA_reg; // R12
  wire detBNext = (cntB_reg > tmrB_reg) ? 1'b1 : // R11
                  below90B ? 1'b0 : detB_reg; // R12
  wire lowCurNext = lowCurRelease ? 1'b0 : // R13
                    (cntL_reg >= tmrA_reg) ? 1'b1 : lowCur_reg; // R13

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {det_reg, uv_reg, run_reg, dip_reg} <= 4'h0;
      {detA_reg, detB_reg, lowCur_reg} <= 3'h0;
      cntA_reg <= 16'h0000;
      cntB_reg <= 16'h0000;
      cntL_reg <= 16'h0000;
    end else if (ce) begin
      {det_reg, uv_reg, run_reg, dip_reg} <=
        {detNext, uvNext, runNext, dipNext};
      {detA_reg, detB_reg, lowCur_reg} <= {detANext, detBNext, lowCurNext};
      cntA_reg <= cntANext;
      cntB_reg <= cntBNext;
      cntL_reg <= cntLNext;
    end
  end

  // ****************************************
  // Minimum ON width
  // ****************************************
  // A short condition is stretched, a long one passes as it is
  logic [HOLD_N-1:0] holdSrc, holdPrev_reg, holdOut;
  logic [3:0] holdCnt_reg [HOLD_N];
  wire limSrc = evt.swCurLimit | evt.hwCurLimit | evt.regenDecel; // R05
  assign holdSrc = {lowCur_reg, detB_reg, detA_reg,
                    evt.ovlPrevActive, limSrc};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      holdPrev_reg <= '0;
      for (int i = 0; i < HOLD_N; i++) holdCnt_reg[i] <= 4'h0;
    end else if (ce) begin
      holdPrev_reg <= holdSrc;
      for (int i = 0; i < HOLD_N; i++) begin
        if (holdSrc[i] && !holdPrev_reg[i])
          holdCnt_reg[i] <= MIN_ON_TICKS; // R25
        else if (tick && holdCnt_reg[i] != 4'h0)
          holdCnt_reg[i] <= holdCnt_reg[i] - 4'h1; // R25
      end
    end
  end
  always_comb begin
    for (int i = 0; i < HOLD_N; i++)
      holdOut[i] = holdSrc[i] | (holdCnt_reg[i] != 4'h0); // R25
  end

  // ****************************************
  // Flag assembly and terminals
  // ****************************************
  dsf_flags_t flagsNext, flags_reg;
  logic startEn_reg, termY_reg, termR_reg;
  always_comb begin
    flagsNext.outputActiveFlag = run_reg; // R24
    flagsNext.freqArrival = arrivalNow; // R01
    flagsNext.freqDetectFlag = det_reg; // R02
    flagsNext.undervoltageFlag = uvFlag; // R03
    flagsNext.outputLimitingFlag = holdOut[0]; // R05
    flagsNext.powerDipRestart = dipModeOk &
                                (evt.rideThrough | dip_reg); // R06
    flagsNext.overloadWarning = aboveA; // R07
    flagsNext.wearoutAlarm = evt.dcCapExpired | evt.pcbCapExpired |
                             evt.fanExpired; // R08
    flagsNext.outputActiveInclBraking = run_reg | evt.dcBraking; // R09
    flagsNext.overloadPreventionFlag = holdOut[1]; // R10
    flagsNext.currentDetectedA = holdOut[2]; // R11
    flagsNext.currentDetectedB = holdOut[3]; // R11
    flagsNext.lowCurrentFlag = holdOut[4]; // R13
    flagsNext.closedLoopActive = !loopCancelLvl && runLvl; // R14
    flagsNext.slowFlowStopped = evt.slowFlowStop; // R15
    flagsNext.secondMotorSelected = motor2Lvl; // R16
    flagsNext.thermistorOverheat = thermMode_reg == THERM_PTC &&
                                   meas.motorTemp >= thermTrip_reg; // R17
    flagsNext.brakeCommand = evt.brakeReq; // R18
    flagsNext.feedbackWireBreak = evt.c1IsFeedback &
                                  evt.c1WireBroken; // R19
    flagsNext.arrivalAndDetect = arrivalNow & det_reg; // R20
    flagsNext.alarmAny = evt.alarmActive; // R21
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= '0;
      {startEn_reg, termY_reg, termR_reg} <= 3'h0;
    end else if (ce) begin
      flags_reg <= flagsNext;
      startEn_reg <= runLvl & ~flagsNext.undervoltageFlag; // R04
      termY_reg <= termOut(flagsNext, selY_reg);
      termR_reg <= termOut(flagsNext, selR_reg);
    end
  end
  assign flags = flags_reg;
  assign motorStartEn = startEn_reg;
  assign termY = termY_reg;
  assign termRelay = termR_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_uv_run_block: assert property ( // R04
    ce && flagsNext.undervoltageFlag |=> !motorStartEn)
    else $error("run accepted during undervoltage");
  a_det_set_high: assert property ( // R02
    ce && meas.outFreq > detLvl_reg |=> det_reg)
    else $error("detect flag not set above level");
  a_det_keeps_on: assert property ( // R02
    ce && det_reg && meas.outFreq >= detLow |=> det_reg)
    else $error("detect flag cleared inside hysteresis");
  a_and_of_two: assert property ( // R20
    flags.arrivalAndDetect == (flags.freqArrival & flags.freqDetectFlag))
    else $error("arrival and detect mismatch");
  a_lim_hold_load: assert property ( // R05
    ce && limSrc && !holdPrev_reg[0] |=>
      holdCnt_reg[0] == MIN_ON_TICKS ##1 flags.outputLimitingFlag || !ce)
    else $error("limiting hold not started");
  a_run_brake_off: assert property ( // R24
    ce && evt.dcBraking |=>
      !run_reg ##1 (!flags.outputActiveFlag || !$past(ce)))
    else $error("running flag on during braking");
  a_output_active_incl_braking_brake_on: assert property ( // R09
    ce && evt.dcBraking |=> flags.outputActiveInclBraking)
    else $error("running-2 flag off during braking");
  a_dip_mode_gate: assert property ( // R06
    ce && !dipModeOk |=> !flags.powerDipRestart)
    else $error("power dip flag outside restart mode");
  a_therm_mode_gate: assert property ( // R17
    ce && thermMode_reg != THERM_PTC |=> !flags.thermistorOverheat)
    else $error("thermistor flag with thermistor off");
  a_lvl_range_keep: assert property ( // R22
    wrEn && regAddr == OFS_CUR_LVL_A && !lvlOk |=>
      lvlA_reg == $past(lvlA_reg))
    else $error("out of range level accepted");
  a_det_a_release: assert property ( // R12
    ce && below90A && cntA_reg <= tmrA_reg |=> !detA_reg)
    else $error("current detect not released");
endmodule : dsf_status_flags

// ===== verif/dsf_term_watch.sv
// Far-side model: equipment watching the two output terminals.
// Assumes the terminals change only on sys_clk edges.
`timescale 1ns/100ps
module dsf_term_watch (
  // Clock
  input wire logic sys_clk,
  // Terminals
  input wire logic termY,
  input wire logic termRelay,
  output logic seenY,
  output logic seenRelay
);
  // Sampled once per edge; a glitch between edges is never seen
  always_ff @(posedge sys_clk) begin
    seenY <= termY;
    seenRelay <= termRelay;
  end
endmodule : dsf_term_watch

// ===== verif/dsf_status_flags_bench.sv
// Bench of the status flag block; status reads are checked from a queue.
// Assumes a short tick so that the 10-tick hold lasts 40 cycles.
`timescale 1ns/100ps
module dsf_status_flags_bench import dsf_pkg::*; ;
  localparam int unsigned TK = 4;
  logic sys_clk = 1'b0, rstn = 1'b0, ce = 1'b0;
  logic [7:0] regAddr = '0;
  logic [31:0] regWrData = '0, regRdData;
  logic regWrStb = 1'b0, regRdStb = 1'b0, rdPend = 1'b0;
  dsf_meas_t meas = '0;
  dsf_evt_t evt = '0;
  logic runCmdPin = 1'b0, loopCancelPin = 1'b0, motorSelectPin = 1'b0;
  logic motorStartEn, termY, termRelay, seenY, seenRelay;
  dsf_flags_t flags;
  logic [63:0] expQ [$];
  logic [63:0] note;
  logic [15:0] t;
  int miscompares = 0, total_checks = 0, seed = 42;
  logic [39:0] rstTab [11] = '{40'h00000000fa, 40'h0400001770,
    40'h0800000064, 40'h0c00000064, 40'h10000003e8, 40'h1400000064,
    40'h18000003e8, 40'h1c00000000, 40'h2000000fa0, 40'h2400630000,
    40'h4000000000};
  logic [17:0] fTab [6] = '{{16'd6001, 2'b11}, {16'd5900, 2'b11},
    {16'd5899, 2'b10}, {16'd5751, 2'b10}, {16'd5750, 2'b00},
    {16'd6000, 2'b10}};
  logic [20:0] eTab [10] = '{{6'h34, 15'h0001}, {6'h31, 15'h0008},
    {6'h2e, 15'h0010}, {6'h27, 15'h0100}, {6'h27, 15'h0080},
    {6'h27, 15'h0040}, {6'h32, 15'h0006}, {6'h12, 15'h0002},
    {6'h28, 15'h0020}, {6'h00, 15'h0020}};
  logic [19:0] hTab [4] = '{{5'd4, 15'h2000}, {5'd4, 15'h1000},
    {5'd4, 15'h0800}, {5'd9, 15'h0400}};
  always #2 sys_clk = ~sys_clk;
  dsf_status_flags #(.TICK_CYCLES(TK)) dut_u (.sys_clk(sys_clk),
    .rstn(rstn), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .meas(meas), .evt(evt), .runCmdPin(runCmdPin),
    .loopCancelPin(loopCancelPin), .motorSelectPin(motorSelectPin),
    .motorStartEn(motorStartEn), .flags(flags), .termY(termY),
    .termRelay(termRelay));
  dsf_term_watch watch_u (.sys_clk(sys_clk), .termY(termY),
    .termRelay(termRelay), .seenY(seenY), .seenRelay(seenRelay));
  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    expQ.push_back({m, e & m});
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
  endtask : rd
  task automatic st(input int b, input logic v);
    rd(OFS_STATUS, 32'(v) << b, 32'h1 << b);
  endtask : st
  task automatic summarize();
    if (miscompares == 0 && total_checks > 0 && expQ.size() == 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rdPend <= regRdStb;
    if (rdPend) begin
      note = expQ.pop_front();
      check("regRdData", regRdData & note[63:32], note[31:0]);
    end
  end
  initial begin
    cyc(60000);
    miscompares++;
    summarize();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    cyc(12);
    rstn <= 1'b1;
    ce <= 1'b1;
    foreach (rstTab[i]) rd(rstTab[i][39:32], rstTab[i][31:0], '1);
    wr(OFS_CUR_LVL_A, 32'd201);
    wr(OFS_CUR_TMR_A, 32'd0);
    wr(OFS_CUR_TMR_A, 32'd60001);
    wr(OFS_CUR_LVL_B, 32'd200);
    wr(OFS_TERM_SEL, 32'h0063044c);
    rd(OFS_CUR_LVL_A, 32'd100, '1);
    rd(OFS_CUR_TMR_A, 32'd1000, '1);
    rd(OFS_CUR_LVL_B, 32'd200, '1);
    rd(OFS_TERM_SEL, 32'h00630000, '1);
    wr(OFS_TERM_SEL, 32'h03e90002);
    meas.refFreq <= 16'd6001;
    foreach (fTab[i]) begin
      meas.outFreq <= fTab[i][17:2];
      cyc(8);
      st(1, fTab[i][1]);
      st(2, fTab[i][0]);
      st(19, &fTab[i][1:0]);
      check("termY", seenY, fTab[i][0]);
      check("termRelay", seenRelay, !fTab[i][1]);
    end
    meas.outFreq <= 16'd6001;
    foreach (eTab[i]) begin
      evt <= dsf_evt_t'(eTab[i][14:0]);
      cyc(6);
      st(eTab[i][19:15], eTab[i][20]);
    end
    foreach (hTab[i]) begin
      evt <= dsf_evt_t'(hTab[i][14:0]);
      cyc(1);
      evt <= '0;
      cyc(24);
      st(hTab[i][19:15], 1'b1);
      cyc(60);
      st(hTab[i][19:15], 1'b0);
    end
    wr(OFS_CUR_TMR_A, 32'd2);
    wr(OFS_CUR_TMR_B, 32'd2);
    meas.outCurrent <= 16'd10001;
    cyc(4);
    st(6, 1'b1);
    st(10, 1'b0);
    cyc(40);
    st(10, 1'b1);
    meas.outCurrent <= 16'd9001;
    cyc(80);
    st(10, 1'b1);
    meas.outCurrent <= 16'd8999;
    cyc(8);
    st(10, 1'b0);
    st(12, 1'b1);
    meas.outCurrent <= 16'd20499;
    cyc(8);
    st(12, 1'b1);
    meas.outCurrent <= 16'd20500;
    cyc(16);
    st(12, 1'b0);
    st(11, 1'b1);
    // Restart mode 4 and thermistor mode 2
    wr(OFS_MODES, 32'h24);
    meas.outFreq <= 16'd0;
    meas.refFreq <= 16'd0;
    meas.uvLevel <= 16'd500;
    meas.dcVolt <= 16'd499;
    runCmdPin <= 1'b1;
    cyc(8);
    st(3, 1'b1);
    st(5, 1'b1);
    check("motorStartEn", motorStartEn, 1'b0);
    meas.dcVolt <= 16'd501;
    motorSelectPin <= 1'b1;
    cyc(8);
    st(3, 1'b0);
    st(5, 1'b0);
    st(13, 1'b1);
    st(15, 1'b1);
    check("motorStartEn", motorStartEn, 1'b1);
    evt.uvTrip <= 1'b1;
    loopCancelPin <= 1'b1;
    cyc(8);
    st(3, 1'b1);
    st(13, 1'b0);
    for (int i = 0; i < 10; i++) begin
      t = (i == 0) ? 16'h0fa0 : (i == 1) ? 16'h0f9f : 16'($random(seed));
      meas.motorTemp <= t;
      cyc(6);
      st(16, t >= 16'h0fa0);
    end
    cyc(4);
    summarize();
  end
endmodule : dsf_status_flags_bench
